// file: src/pwt_ctrl.sv
// control register set of the pwm timer with command synchronisation
// ************************************
// ************************************
//
// Implementation choice: the APB interface to the registers.
module pwt_ctrl
  import pwt_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FAST_OSC_CLK,
  input wire logic EXT_CLK,
  input wire logic CYCLE_END,
  input wire logic [1:0] TIMER_PHASE,
  input wire logic WAVE_A_DEFAULT,
  input wire logic WAVE_B_DEFAULT,
  input wire logic CMP_WR,
  input wire logic [1:0] CMP_SEL,
  input wire logic CMP_HIGH,
  output logic CMP_MIRROR_WR,
  output logic TIMER_RUN,
  output logic SYNC_TICK,
  output logic COUNT_TICK,
  output pwt_mode_e WAVE_MODE,
  output pwt_cmd_s CMD_PULSE,
  output logic BUFFER_LOAD,
  output logic WAVE_OUT_A,
  output logic WAVE_OUT_B,
  output logic WAVE_OUT_C,
  output logic WAVE_OUT_D
);

  // ************************************
  // declarations
  // ************************************
  logic [7:0] clock_and_enable_control_r;
  logic [7:0] waveform_mode_control_r;
  logic [7:0] output_routing_control_r;
  logic [7:0] override_level_control_r;
  logic [1:0] fast_sync_r;
  logic [1:0] ext_sync_r;
  logic fast_prev_r;
  logic ext_prev_r;
  logic src_tick;
  logic [2:0] sync_div_r;
  logic [2:0] sync_last;
  logic [4:0] cnt_div_r;
  logic [4:0] cnt_last;
  logic sync_tick;
  logic en_busy_r;
  logic [1:0] en_cnt_r;
  logic en_target_r;
  logic dis_pend_r;
  logic run_r;
  logic cmd_busy_r;
  logic [1:0] cmd_cnt_r;
  pwt_cmd_s cmd_pend_r;
  logic end_sync_r;
  pwt_cmd_s cmd_pulse_r;
  logic load_r;
  logic mirror_r;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic mapped;
  logic [7:0] status;
  logic auto_req;
  logic [1:0] phase;
  logic lvl_a;
  logic lvl_b;
  logic wave_a;
  logic wave_b;
  logic wa_r;
  logic wb_r;
  logic wc_r;
  logic wd_r;

  // ************************************
  // apb decode
  // ************************************
  assign idx = PADDR[ADDR_W-1:WORD_SHIFT];
  assign wdat = PWDATA[7:0];
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign mapped = (PADDR[WORD_SHIFT-1:0] == 2'h0) &&
                  ((idx <= COMMAND_STROBE_CONTROL_IDX) || (idx == TIMER_STATUS_IDX));
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign status = {6'h00, !cmd_busy_r, !en_busy_r};

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd && !PENABLE) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR[ADDR_W-1:WORD_SHIFT])
        CLOCK_AND_ENABLE_CONTROL_IDX: PRDATA <= {24'h0, clock_and_enable_control_r};
        WAVEFORM_MODE_CONTROL_IDX: PRDATA <= {24'h0, waveform_mode_control_r};
        OUTPUT_ROUTING_CONTROL_IDX: PRDATA <= {24'h0, output_routing_control_r};
        OVERRIDE_LEVEL_CONTROL_IDX: PRDATA <= {24'h0, override_level_control_r};
        COMMAND_STROBE_CONTROL_IDX: PRDATA <= {24'h0, dis_pend_r, 2'h0, cmd_pend_r, end_sync_r};
        TIMER_STATUS_IDX: PRDATA <= {24'h0, status};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************
  // configuration registers
  // ************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      clock_and_enable_control_r <= CTRL_RESET;
    end else begin
      if (wr && mapped && idx == CLOCK_AND_ENABLE_CONTROL_IDX) begin
        if (!clock_and_enable_control_r[EN_BIT]) begin
          clock_and_enable_control_r[6:1] <= wdat[6:1];
        end
        if (!en_busy_r) begin
          clock_and_enable_control_r[EN_BIT] <= wdat[EN_BIT];
        end
      end
      if (dis_pend_r && (CYCLE_END || !run_r)) begin
        clock_and_enable_control_r[EN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      waveform_mode_control_r <= CTRL_RESET;
      output_routing_control_r <= CTRL_RESET;
      override_level_control_r <= CTRL_RESET;
    end else if (wr && mapped) begin
      if (idx == WAVEFORM_MODE_CONTROL_IDX) begin
        waveform_mode_control_r <= wdat & WAVEFORM_MODE_CONTROL_MASK;
      end
      if (idx == OUTPUT_ROUTING_CONTROL_IDX) begin
        output_routing_control_r <= wdat & OUTPUT_ROUTING_CONTROL_MASK;
      end
      if (idx == OVERRIDE_LEVEL_CONTROL_IDX) begin
        override_level_control_r <= wdat;
      end
    end
  end

  // ************************************
  // timer clock source and prescalers
  // ************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      fast_sync_r <= 2'h0;
      ext_sync_r <= 2'h0;
      fast_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      fast_sync_r <= {fast_sync_r[0], FAST_OSC_CLK};
      ext_sync_r <= {ext_sync_r[0], EXT_CLK};
      fast_prev_r <= fast_sync_r[1];
      ext_prev_r <= ext_sync_r[1];
    end
  end

  always_comb begin
    unique case (clock_and_enable_control_r[CLOCK_SOURCE_SELECT_LSB+:2])
      SRC_INTERNAL_FAST_OSC: src_tick = fast_sync_r[1] && !fast_prev_r;
      SRC_EXTERNAL: src_tick = ext_sync_r[1] && !ext_prev_r;
      SRC_SYSTEM: src_tick = 1'b1;
      default: src_tick = 1'b0;
    endcase
  end

  // divide by 2 to the code
  assign sync_last = 3'((4'h1 << clock_and_enable_control_r[SYNCPS_LSB+:2]) - 4'h1);
  assign sync_tick = src_tick && (sync_div_r == sync_last);

  always_comb begin
    unique case (clock_and_enable_control_r[CNTPS_LSB+:2])
      CNTPS_DIV1: cnt_last = 5'h00;
      CNTPS_DIV4: cnt_last = CNT_DIV4_LAST;
      CNTPS_DIV32: cnt_last = CNT_DIV32_LAST;
      default: cnt_last = 5'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sync_div_r <= 3'h0;
      cnt_div_r <= 5'h00;
    end else begin
      if (src_tick) begin
        sync_div_r <= (sync_div_r >= sync_last) ? 3'h0 : sync_div_r + 3'h1;
      end
      if (sync_tick) begin
        cnt_div_r <= (cnt_div_r >= cnt_last) ? 5'h00 : cnt_div_r + 5'h01;
      end
    end
  end

  assign SYNC_TICK = sync_tick;
  assign COUNT_TICK = sync_tick && run_r && (cnt_div_r >= cnt_last);

  // ************************************
  // enable synchronisation
  // ************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      en_busy_r <= 1'b0;
      en_cnt_r <= 2'h0;
      en_target_r <= 1'b0;
      dis_pend_r <= 1'b0;
      run_r <= 1'b0;
    end else if (en_busy_r) begin
      if (dis_pend_r) begin
        if (CYCLE_END || !run_r) begin
          run_r <= 1'b0;
          dis_pend_r <= 1'b0;
          en_busy_r <= 1'b0;
        end
      end else if (sync_tick) begin
        if (en_cnt_r == SYNC_TICKS - 2'h1) begin
          run_r <= en_target_r;
          en_busy_r <= 1'b0;
          en_cnt_r <= 2'h0;
        end else begin
          en_cnt_r <= en_cnt_r + 2'h1;
        end
      end
    end else if (wr && mapped && idx == COMMAND_STROBE_CONTROL_IDX && wdat[DISEND_BIT]) begin
      dis_pend_r <= 1'b1;
      en_busy_r <= 1'b1;
    end else if (wr && mapped && idx == CLOCK_AND_ENABLE_CONTROL_IDX &&
                 wdat[EN_BIT] != clock_and_enable_control_r[EN_BIT]) begin
      en_target_r <= wdat[EN_BIT];
      en_busy_r <= 1'b1;
      en_cnt_r <= 2'h0;
    end
  end

  assign TIMER_RUN = run_r;

  // ************************************
  // command strobes
  // ************************************
  assign auto_req = CMP_WR && CMP_HIGH && output_routing_control_r[AUPD_BIT] &&
                    ((CMP_SEL == CMP_B_CLR) ||
                     (CMP_SEL == CMP_A_CLR && output_routing_control_r[FIFTY_BIT]));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cmd_busy_r <= 1'b0;
      cmd_cnt_r <= 2'h0;
      cmd_pend_r <= '0;
      cmd_pulse_r <= '0;
      end_sync_r <= 1'b0;
      load_r <= 1'b0;
    end else begin
      cmd_pulse_r <= '0;
      load_r <= 1'b0;
      if (cmd_busy_r) begin
        if (cmd_cnt_r == SYNC_TICKS) begin
          if (CYCLE_END) begin
            load_r <= 1'b1;
            end_sync_r <= 1'b0;
            cmd_busy_r <= 1'b0;
            cmd_cnt_r <= 2'h0;
          end
        end else if (sync_tick) begin
          if (cmd_cnt_r == SYNC_TICKS - 2'h1) begin
            cmd_pulse_r <= cmd_pend_r;
            load_r <= cmd_pend_r.sync_now;
            cmd_pend_r <= '0;
            cmd_busy_r <= end_sync_r;
            // synced, park until the cycle end when end_sync_r is set
            cmd_cnt_r <= end_sync_r ? SYNC_TICKS : 2'h0;
          end else begin
            cmd_cnt_r <= cmd_cnt_r + 2'h1;
          end
        end
      end else if (wr && mapped && idx == COMMAND_STROBE_CONTROL_IDX &&
                   (wdat[SCAPB_BIT:SYNCEND_BIT] != 5'h00)) begin
        cmd_pend_r <= wdat[SCAPB_BIT:SYNCNOW_BIT];
        end_sync_r <= wdat[SYNCEND_BIT];
        cmd_busy_r <= 1'b1;
        cmd_cnt_r <= 2'h0;
      end else if (auto_req) begin
        end_sync_r <= 1'b1;
        cmd_busy_r <= 1'b1;
        cmd_cnt_r <= 2'h0;
      end
    end
  end

  assign CMD_PULSE = cmd_pulse_r;
  assign BUFFER_LOAD = load_r;

  // ************************************
  // compare mirroring
  // ************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      mirror_r <= 1'b0;
    end else begin
      // mirror a set and clear writes
      mirror_r <= CMP_WR && output_routing_control_r[FIFTY_BIT] &&
                  (CMP_SEL == CMP_A_SET || CMP_SEL == CMP_A_CLR);
    end
  end

  assign CMP_MIRROR_WR = mirror_r;

  // ************************************
  // waveform override and routing
  // ************************************
  // mode field
  assign WAVE_MODE = pwt_mode_e'(waveform_mode_control_r[1:0]);
  assign phase = TIMER_PHASE;

  always_comb begin
    lvl_a = WAVE_A_DEFAULT;
    lvl_b = WAVE_B_DEFAULT;
    if (WAVE_MODE == SINGLE_RAMP) begin
      if (phase == DEAD_TIME_A) begin
        lvl_a = override_level_control_r[LVLA_LSB + 1];
      end else if (phase == ON_TIME_A) begin
        lvl_a = override_level_control_r[LVLA_LSB];
      end else if (phase == DEAD_TIME_B) begin
        lvl_b = override_level_control_r[LVLB_LSB + 3];
      end else begin
        lvl_b = override_level_control_r[LVLB_LSB + 2];
      end
    end else begin
      lvl_a = override_level_control_r[LVLA_LSB + 32'(phase)];
      lvl_b = override_level_control_r[LVLB_LSB + 32'(phase)];
    end
  end

  assign wave_a = output_routing_control_r[OVR_BIT] ? lvl_a : WAVE_A_DEFAULT;
  assign wave_b = output_routing_control_r[OVR_BIT] ? lvl_b : WAVE_B_DEFAULT;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wa_r <= 1'b0;
      wb_r <= 1'b0;
      wc_r <= 1'b0;
      wd_r <= 1'b0;
    end else begin
      wa_r <= wave_a;
      wb_r <= wave_b;
      wc_r <= output_routing_control_r[OUTC_BIT] ? wave_b : wave_a;
      wd_r <= output_routing_control_r[OUTD_BIT] ? wave_b : wave_a;
    end
  end

  assign WAVE_OUT_A = wa_r;
  assign WAVE_OUT_B = wb_r;
  assign WAVE_OUT_C = wc_r;
  assign WAVE_OUT_D = wd_r;

endmodule

// file: src/pwt_pkg.sv
// shared constants and types of the pwm timer control registers
package pwt_pkg;

  // ************************************
  // register indices and bus addressing
  // ************************************
  localparam logic [7:0] CLOCK_AND_ENABLE_CONTROL_IDX = 8'h00;
  localparam logic [7:0] WAVEFORM_MODE_CONTROL_IDX = 8'h01;
  localparam logic [7:0] OUTPUT_ROUTING_CONTROL_IDX = 8'h02;
  localparam logic [7:0] OVERRIDE_LEVEL_CONTROL_IDX = 8'h03;
  localparam logic [7:0] COMMAND_STROBE_CONTROL_IDX = 8'h04;
  localparam logic [7:0] TIMER_STATUS_IDX = 8'h0e;
  localparam int ADDR_W = 10;
  localparam int WORD_SHIFT = 2;

  // ************************************
  // field positions
  // ************************************
  localparam int EN_BIT = 0;
  localparam int SYNCPS_LSB = 1;
  localparam int CNTPS_LSB = 3;
  localparam int CLOCK_SOURCE_SELECT_LSB = 5;
  localparam int OUTD_BIT = 7;
  localparam int OUTC_BIT = 6;
  localparam int FIFTY_BIT = 3;
  localparam int AUPD_BIT = 1;
  localparam int OVR_BIT = 0;
  localparam int LVLA_LSB = 0;
  localparam int LVLB_LSB = 4;
  localparam int DISEND_BIT = 7;
  localparam int SCAPB_BIT = 4;
  localparam int SCAPA_BIT = 3;
  localparam int RESTART_BIT = 2;
  localparam int SYNCNOW_BIT = 1;
  localparam int SYNCEND_BIT = 0;
  localparam int ENABLE_READY_BIT = 0;
  localparam int COMMAND_READY_BIT = 1;

  // ************************************
  // reset values and write masks
  // ************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CLOCK_AND_ENABLE_CONTROL_MASK = 8'h7f;
  localparam logic [7:0] WAVEFORM_MODE_CONTROL_MASK = 8'h03;
  localparam logic [7:0] OUTPUT_ROUTING_CONTROL_MASK = 8'hcb;

  // ************************************
  // encodings and timing
  // ************************************
  localparam logic [1:0] SRC_INTERNAL_FAST_OSC = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h2;
  localparam logic [1:0] SRC_SYSTEM = 2'h3;
  localparam logic [1:0] CNTPS_DIV1 = 2'h0;
  localparam logic [1:0] CNTPS_DIV4 = 2'h1;
  localparam logic [1:0] CNTPS_DIV32 = 2'h2;
  localparam logic [4:0] CNT_DIV4_LAST = 5'h03;
  localparam logic [4:0] CNT_DIV32_LAST = 5'h1f;
  localparam logic [1:0] SYNC_TICKS = 2'h2;
  localparam logic [1:0] CMP_A_SET = 2'h0;
  localparam logic [1:0] CMP_A_CLR = 2'h1;
  localparam logic [1:0] CMP_B_SET = 2'h2;
  localparam logic [1:0] CMP_B_CLR = 2'h3;

  typedef enum logic [1:0] {
    SINGLE_RAMP,
    DOUBLE_RAMP,
    QUAD_RAMP,
    DUAL_SLOPE
  } pwt_mode_e;

  typedef enum logic [1:0] {
    DEAD_TIME_A,
    ON_TIME_A,
    DEAD_TIME_B,
    ON_TIME_B
  } pwt_phase_e;

  typedef struct packed {
    logic soft_capture_b;
    logic soft_capture_a;
    logic restart;
    logic sync_now;
  } pwt_cmd_s;

endpackage

// file: test/pwt_ctrl_monitor.sv
// assertion checker bound to the pwm timer control registers
module pwt_ctrl_monitor
  import pwt_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [1:0] TIMER_PHASE,
  input wire logic WAVE_A_DEFAULT,
  input wire logic WAVE_B_DEFAULT,
  input wire logic CMP_WR,
  input wire logic [1:0] CMP_SEL,
  input wire logic CMP_MIRROR_WR,
  input wire logic TIMER_RUN,
  input wire logic COUNT_TICK,
  input wire pwt_mode_e WAVE_MODE,
  input wire pwt_cmd_s CMD_PULSE,
  input wire logic BUFFER_LOAD,
  input wire logic WAVE_OUT_A,
  input wire logic WAVE_OUT_B,
  input wire logic WAVE_OUT_C,
  input wire logic WAVE_OUT_D
);
  // ****
  // shadow registers and expected outputs
  // ****
  logic [7:0] rt_r;
  logic [7:0] lv_r;
  logic [1:0] wm_r;
  logic [3:0] ex_r;
  logic wa;
  logic wb;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rt_r <= 8'h00;
      lv_r <= 8'h00;
      wm_r <= 2'h0;
    end else if (PSEL && PENABLE && PWRITE) begin
      if (PADDR == 10'h004) wm_r <= PWDATA[1:0];
      if (PADDR == 10'h008) rt_r <= PWDATA[7:0] & OUTPUT_ROUTING_CONTROL_MASK;
      if (PADDR == 10'h00c) lv_r <= PWDATA[7:0];
    end
  end
  always_comb begin
    wa = WAVE_A_DEFAULT;
    wb = WAVE_B_DEFAULT;
    if (rt_r[0] && wm_r != 2'h0) begin
      wa = lv_r[TIMER_PHASE];
      wb = lv_r[4 + TIMER_PHASE];
    end else if (rt_r[0] && !TIMER_PHASE[1]) begin
      wa = lv_r[!TIMER_PHASE[0]];
    end else if (rt_r[0]) begin
      wb = lv_r[6 + !TIMER_PHASE[0]];
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) ex_r <= 4'h0;
    else ex_r <= {rt_r[7] ? wb : wa, rt_r[6] ? wb : wa, wb, wa};
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  chk_wave_a_level: assert property (WAVE_OUT_A == ex_r[0])
    else $error("wave a level wrong");
  chk_wave_b_level: assert property (WAVE_OUT_B == ex_r[1])
    else $error("wave b level wrong");
  chk_route_c: assert property (WAVE_OUT_C == ex_r[2])
    else $error("output c routing wrong");
  chk_route_d: assert property (WAVE_OUT_D == ex_r[3])
    else $error("output d routing wrong");
  chk_mode_field: assert property (WAVE_MODE == wm_r)
    else $error("mode output differs from register");
  chk_fifty_mirror: assert property (CMP_WR && !CMP_SEL[1] && rt_r[3] |=> CMP_MIRROR_WR)
    else $error("mirror write missing");
  chk_cmd_single: assert property (CMD_PULSE != 4'h0 |=> CMD_PULSE == 4'h0)
    else $error("command pulse longer than one cycle");
  chk_count_idle: assert property (!TIMER_RUN |-> !COUNT_TICK)
    else $error("counter tick while stopped");
  chk_load_pulse: assert property ($rose(BUFFER_LOAD) |=> !BUFFER_LOAD)
    else $error("buffer load longer than one cycle");
  cov_mirror: cover property (CMP_MIRROR_WR);
  cov_restart: cover property (CMD_PULSE.restart);
  cov_load: cover property (BUFFER_LOAD);
endmodule

bind pwt_ctrl pwt_ctrl_monitor u_mon (.*);

// file: test/test_pwm_timer_control_regs.sv
// self-checking bench of the pwm timer control registers
module test_pwm_timer_control_regs import pwt_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic CORE_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 10'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, FAST_OSC_CLK = 1'b0, EXT_CLK = 1'b0, CYCLE_END = 1'b0;
  logic [1:0] TIMER_PHASE = 2'h0, CMP_SEL = 2'h0;
  logic WAVE_A_DEFAULT = 1'b0, WAVE_B_DEFAULT = 1'b0, CMP_WR = 1'b0, CMP_HIGH = 1'b0;
  logic CMP_MIRROR_WR, TIMER_RUN, SYNC_TICK, COUNT_TICK, BUFFER_LOAD;
  logic WAVE_OUT_A, WAVE_OUT_B, WAVE_OUT_C, WAVE_OUT_D;
  pwt_mode_e WAVE_MODE;
  pwt_cmd_s CMD_PULSE;
  int fails = 0;
  int samples_checked = 0;
  int nbl;
  logic [15:0] lf = 16'h4060;
  logic [31:0] rd;
  logic er;
  logic [3:0] seen;
  logic [7:0] rt, lv;
  logic [1:0] wm;
  logic [7:0] cfgs [7] = '{8'h60, 8'h6a, 8'h74, 8'h7e, 8'h48, 8'h02, 8'h20};
  int ns;
  int nc;

  pwt_ctrl dut (.*);

  initial begin
    forever #12.5 CORE_CLK = ~CORE_CLK;
  end

  // free-running oscillator and external clock
  always @(posedge CORE_CLK) begin
    {EXT_CLK, FAST_OSC_CLK} <= {EXT_CLK, FAST_OSC_CLK} + 2'h1;
  end

  // ****
  // helpers
  // ****
  function automatic logic [15:0] rnd(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [3:0] wexp(logic [7:0] r, logic [7:0] l, logic [1:0] m,
                                      logic [1:0] p, logic da, logic db);
    logic a;
    logic b;
    a = da;
    b = db;
    if (r[0] && m != 2'h0) begin
      a = l[p];
      b = l[4 + p];
    end else if (r[0] && !p[1]) begin
      a = l[!p[0]];
    end else if (r[0]) begin
      b = l[6 + !p[0]];
    end
    return {r[7] ? b : a, r[6] ? b : a, b, a};
  endfunction

  // ticks expected in 256 cycles for a clock config
  function automatic int exp_ticks(logic [7:0] c, bit cnt);
    int s;
    case (c[6:5])
      2'h0: s = 128;
      2'h2: s = 64;
      2'h3: s = 256;
      default: s = 0;
    endcase
    s = s >> c[2:1];
    if (cnt && c[4:3] == 2'h1) s = s / 4;
    if (cnt && c[4:3] == 2'h2) s = s / 32;
    return s;
  endfunction

  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {a, 2'h0};
    PWDATA <= {24'h0, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) fails++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic watch(int n);
    seen = 4'h0;
    nbl = 0;
    repeat (n) begin
      @(negedge CORE_CLK);
      seen = seen | CMD_PULSE;
      nbl += int'(BUFFER_LOAD === 1'b1);
    end
  endtask

  task automatic cyc_end();
    @(posedge CORE_CLK);
    CYCLE_END <= 1'b1;
    @(posedge CORE_CLK);
    CYCLE_END <= 1'b0;
  endtask

  task automatic wait_rdy();
    repeat (40) begin
      apb(1'b0, TIMER_STATUS_IDX, 8'h00);
      if (rd[1:0] === 2'h3) break;
    end
    if (rd[1:0] !== 2'h3) fails++;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    fails++;
    print_verdict();
  end

  // ****
  // tests
  // ****
  initial begin
    repeat (4) @(posedge CORE_CLK);
    RST <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, i[7:0], 8'h00);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, TIMER_STATUS_IDX, 8'h00);
    check("status reset", rd, 32'h3);
    apb(1'b1, 8'h05, 8'h5a);
    check("unmapped error", er, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, WAVEFORM_MODE_CONTROL_IDX, {lf[7:2], i[1:0]});
      lf = rnd(lf);
      @(negedge CORE_CLK);
      check("mode output", WAVE_MODE, i);
      apb(1'b0, WAVEFORM_MODE_CONTROL_IDX, 8'h00);
      check("mode read", rd, i);
    end
    $display("test registers done");
    apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h61);
    repeat (2) @(negedge CORE_CLK);
    check("run early", TIMER_RUN, 32'h0);
    @(negedge CORE_CLK);
    check("run late", TIMER_RUN, 32'h1);
    wait_rdy();
    apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h66);
    apb(1'b0, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h00);
    check("locked fields", rd, 32'h60);
    wait_rdy();
    apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h66);
    apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h67);
    apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h66);
    apb(1'b0, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h00);
    check("enable while pending", rd, 32'h67);
    wait_rdy();
    check("running", TIMER_RUN, 32'h1);
    $display("test enable done");
    apb(1'b1, COMMAND_STROBE_CONTROL_IDX, 8'h80);
    repeat (40) @(posedge CORE_CLK);
    check("run before end", TIMER_RUN, 32'h1);
    apb(1'b0, TIMER_STATUS_IDX, 8'h00);
    check("enable ready low", rd[0], 32'h0);
    cyc_end();
    wait_rdy();
    check("run after end", TIMER_RUN, 32'h0);
    apb(1'b0, CLOCK_AND_ENABLE_CONTROL_IDX, 8'h00);
    check("enable cleared", rd, 32'h66);
    $display("test disable done");
    for (int b = 1; b < 5; b++) begin
      apb(1'b1, COMMAND_STROBE_CONTROL_IDX, 8'h01 << b);
      apb(1'b1, COMMAND_STROBE_CONTROL_IDX, b == 4 ? 8'h08 : 8'h10);
      watch(60);
      check("command pulse", seen, 4'h1 << (b - 1));
      check("sync load", nbl, b == 1);
      apb(1'b0, COMMAND_STROBE_CONTROL_IDX, 8'h00);
      check("strobe cleared", rd, 32'h0);
    end
    apb(1'b1, COMMAND_STROBE_CONTROL_IDX, 8'h01);
    watch(40);
    check("early load", nbl, 32'h0);
    cyc_end();
    watch(4);
    check("end load", nbl, 32'h1);
    $display("test commands done");
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OUTPUT_ROUTING_CONTROL_IDX, k == 1 ? 8'h0a : 8'h02);
      @(posedge CORE_CLK);
      CMP_WR <= 1'b1;
      CMP_SEL <= k == 0 ? CMP_B_CLR : CMP_A_CLR;
      CMP_HIGH <= 1'b1;
      @(posedge CORE_CLK);
      CMP_WR <= 1'b0;
      apb(1'b0, TIMER_STATUS_IDX, 8'h00);
      check("auto busy", rd[1], k == 2);
      watch(40);
      cyc_end();
      watch(4);
      check("auto load", nbl, k != 2);
    end
    $display("test auto update done");
    for (int k = 0; k < 40; k++) begin
      rt = (lf[7:0] & 8'hc8) | {7'h0, k[0] | k[1]};
      apb(1'b1, OUTPUT_ROUTING_CONTROL_IDX, rt);
      lf = rnd(lf);
      lv = lf[7:0];
      wm = lf[9:8];
      apb(1'b1, OVERRIDE_LEVEL_CONTROL_IDX, lv);
      apb(1'b1, WAVEFORM_MODE_CONTROL_IDX, {6'h0, wm});
      repeat (4) begin
        @(posedge CORE_CLK);
        lf = rnd(lf);
        TIMER_PHASE <= lf[1:0];
        WAVE_A_DEFAULT <= lf[2];
        WAVE_B_DEFAULT <= lf[3];
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        check("wave outputs", {WAVE_OUT_D, WAVE_OUT_C, WAVE_OUT_B, WAVE_OUT_A},
              wexp(rt, lv, wm, lf[1:0], lf[2], lf[3]));
      end
    end
    $display("test waveforms done");
    for (int j = 0; j < 7; j++) begin
      apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, {cfgs[j][7:1], j != 6});
      if (j != 6) wait_rdy();
      repeat (40) @(posedge CORE_CLK);
      ns = 0;
      nc = 0;
      repeat (256) begin
        @(negedge CORE_CLK);
        ns += int'(SYNC_TICK === 1'b1);
        nc += int'(COUNT_TICK === 1'b1);
      end
      check("sync ticks", ns, exp_ticks(cfgs[j], 1'b0));
      check("count ticks", nc, exp_ticks(cfgs[j], 1'b1));
      if (j != 6) begin
        apb(1'b1, CLOCK_AND_ENABLE_CONTROL_IDX, cfgs[j]);
        wait_rdy();
      end
    end
    $display("test clock done");
    print_verdict();
  end
endmodule
